// File: logic/bringup_controller.sv
// Purpose: controller end: power-down pin timing and bring-up writes
// Assumes: software starts the sequence and reads status over APB
// Notes: zero-wait APB slave; long waits are top-level parameters
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module bringup_controller #(
   parameter int unsigned T1_CYC = bringup_pkg::SUPPLY_TO_PD_CYC,
   parameter int unsigned T2_CYC = bringup_pkg::PD_HIGH_BEFORE_HARD_CYC,
   parameter int unsigned T3_CYC = bringup_pkg::PD_LOW_PULSE_CYC,
   parameter int unsigned T4_CYC = bringup_pkg::PD_TO_READY_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   bringup_if.host_mp ctl,
   input wire logic core_supply_stable,
   input wire logic rx_link_lock,
   input wire logic [2:0] remote_die_temperature_code,
   output logic sequence_done
);
   import bringup_pkg::*;

   host_state_t state_q, state_d;
   logic [1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   logic [CNT_W-1:0] cnt_q, pdh_cnt_q;
   logic pdh_ok_q, pd_q, pd_d;
   logic req_q, we_q;
   logic [7:0] addr_q, wdata_q;
   logic [7:0] static_wr_q, dyn_rd_q, dyn_wr_q, rd_q;
   logic [2:0] temp_q;
   logic [31:0] prdata_q;
   logic bus_state, op_we, cnt_done, supply_ok, lock_ok;
   logic [7:0] op_addr, op_wdata, offset, dyn_adj;
   logic apb_setup, apb_access, apb_wr, start_cmd, hard_cmd;
   logic hit_ctrl, hit_status, hit_result;

   // Supply and lock pins filtered before use
   assign filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
         filt_q <= 2'h0;
      end else begin
         s1_q <= {rx_link_lock, core_supply_stable};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end
   assign supply_ok = filt_q[0];
   assign lock_ok = filt_q[1];

   // APB decode; commands are write pulses in CTRL
   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable;
   assign apb_wr = apb_access & pwrite;
   assign hit_ctrl = (paddr == APB_CTRL);
   assign hit_status = (paddr == APB_STATUS);
   assign hit_result = (paddr == APB_RESULT);
   assign start_cmd = apb_wr & hit_ctrl & pwdata[0];
   assign hard_cmd = apb_wr & hit_ctrl & pwdata[1];
   assign pready = 1'b1;
   assign pslverr = apb_access & ~(hit_ctrl | hit_status | hit_result);
   assign prdata = prdata_q;

   // Read data captured in setup so access phase shows a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (apb_setup) begin
         prdata_q <= hit_status ? {22'h0, temp_q, lock_ok, pd_q,
                                   (state_q == ST_DONE), state_q} :
                     hit_result ? {8'h00, dyn_wr_q, dyn_rd_q, static_wr_q} :
                     32'h0000_0000;
      end
   end

   assign offset = (temp_q < 3'h2) ? 8'hff :
                   (temp_q < 3'h4) ? 8'h00 :
                   (temp_q < 3'h7) ? 8'h01 : 8'h03;
   // adjust read-back value; force enable bit
   assign dyn_adj = 8'((dyn_rd_q | DYN_ENABLE_MASK) + offset)
                    | DYN_ENABLE_MASK;

   // Bus operation of each access state
   assign bus_state = (state_q == ST_WDOG) || (state_q == ST_RD_STATIC) ||
                      (state_q == ST_WR_STATIC) || (state_q == ST_RD_DYN) ||
                      (state_q == ST_WR_DYN) || (state_q == ST_SOFT_RST);
   assign op_we = (state_q == ST_WDOG) || (state_q == ST_WR_STATIC) ||
                  (state_q == ST_WR_DYN) || (state_q == ST_SOFT_RST);
   assign op_addr = (state_q == ST_WDOG) ? REG_WDOG :
                    (state_q == ST_SOFT_RST) ? REG_SOFT_RESET :
                    (state_q == ST_RD_DYN || state_q == ST_WR_DYN) ?
                    REG_DYN : REG_STATIC;
   // watchdog value; static field; soft reset value
   assign op_wdata = (state_q == ST_WDOG) ? WDOG_SPEEDUP_VAL :
                     (state_q == ST_WR_STATIC) ?
                     ((rd_q & STATIC_KEEP_MASK) | STATIC_FIELD_VAL) :
                     (state_q == ST_WR_DYN) ? dyn_adj :
                     (state_q == ST_SOFT_RST) ? SOFT_RESET_VAL : 8'h00;

   assign cnt_done =
      (state_q == ST_OFF) ? (cnt_q >= CNT_W'(T1_CYC - 1)) :
      (state_q == ST_HR_LOW) ? (cnt_q >= CNT_W'(T3_CYC - 1)) :
      (cnt_q >= CNT_W'(T4_CYC - 1));

   always_comb begin
      state_d = state_q;
      case (state_q)
         // pin stays low until supply stable
         ST_OFF: if (supply_ok && cnt_done) state_d = ST_WAIT_READY;
         ST_WAIT_READY: if (cnt_done) state_d = ST_IDLE;
         ST_IDLE, ST_DONE: begin
            if (hard_cmd) state_d = ST_HR_WAIT;
            else if (start_cmd) state_d = ST_WDOG;
         end
         ST_WDOG: if (ctl.ctl_ack) state_d = ST_RD_STATIC;
         ST_RD_STATIC: if (ctl.ctl_ack) state_d = ST_WR_STATIC;
         ST_WR_STATIC: if (ctl.ctl_ack) state_d = ST_TEMP;
         ST_TEMP: state_d = ST_RD_DYN;
         ST_RD_DYN: if (ctl.ctl_ack) state_d = ST_WR_DYN;
         ST_WR_DYN: if (ctl.ctl_ack) state_d = ST_SOFT_RST;
         ST_SOFT_RST: if (ctl.ctl_ack) state_d = ST_WAIT_LOCK;
         // wait for receiver lock; guard time outlasts the lock
         // filter so a stale lock from before the soft reset is ignored
         ST_WAIT_LOCK: if (lock_ok && cnt_done) state_d = ST_DONE;
         // pin high long enough before hard reset
         ST_HR_WAIT: if (pdh_ok_q) state_d = ST_HR_LOW;
         ST_HR_LOW: if (cnt_done) state_d = ST_WAIT_READY;
         default: state_d = ST_OFF;
      endcase
      if (!supply_ok) state_d = ST_OFF;
   end
   assign pd_d = (state_d != ST_OFF) && (state_d != ST_HR_LOW);

   // State, wait counter and pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_OFF;
         cnt_q <= '0;
         pd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pd_q <= pd_d;
         if (state_d != state_q) cnt_q <= '0;
         else if (!cnt_done) cnt_q <= cnt_q + 1'b1;
      end
   end

   // time pin has been high, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdh_cnt_q <= '0;
         pdh_ok_q <= 1'b0;
      end else if (!pd_q) begin
         pdh_cnt_q <= '0;
         pdh_ok_q <= 1'b0;
      end else if (!pdh_ok_q) begin
         pdh_cnt_q <= pdh_cnt_q + 1'b1;
         pdh_ok_q <= (pdh_cnt_q >= CNT_W'(T2_CYC - 1));
      end
   end

   // Request held until the one-cycle answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         rd_q <= 8'h00;
      end else if (!bus_state || ctl.ctl_ack) begin
         req_q <= 1'b0;
         if (ctl.ctl_ack) rd_q <= ctl.ctl_rdata;
      end else if (!req_q) begin
         req_q <= 1'b1;
         we_q <= op_we;
         addr_q <= op_addr;
         wdata_q <= op_wdata;
      end
   end

   // capture code and values along the way
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_q <= 3'h0;
         static_wr_q <= 8'h00;
         dyn_rd_q <= 8'h00;
         dyn_wr_q <= 8'h00;
      end else begin
         if (state_q == ST_TEMP) temp_q <= remote_die_temperature_code;
         if (state_q == ST_WR_STATIC && !req_q) static_wr_q <= op_wdata;
         if (state_q == ST_RD_DYN && ctl.ctl_ack) dyn_rd_q <= ctl.ctl_rdata;
         if (state_q == ST_WR_DYN && !req_q) dyn_wr_q <= op_wdata;
      end
   end

   assign ctl.power_down_input = pd_q;
   assign ctl.ctl_req = req_q;
   assign ctl.ctl_we = we_q;
   assign ctl.ctl_addr = addr_q;
   assign ctl.ctl_wdata = wdata_q;
   assign sequence_done = (state_q == ST_DONE);
endmodule // bringup_controller
`default_nettype wire

// File: logic/bringup_if.sv
// Purpose: power-down pin and register access port between the two ends
// Assumes: both ends run on the same pclk
// Notes: ctl_ack is a one-cycle pulse answering a held ctl_req
`timescale 1ns/10ps
`default_nettype none
interface bringup_if;
   logic power_down_input;
   logic ctl_req;
   logic ctl_we;
   logic [7:0] ctl_addr;
   logic [7:0] ctl_wdata;
   logic ctl_ack;
   logic [7:0] ctl_rdata;
   // Controller end drives the pin and requests
   modport host_mp (
      output power_down_input, ctl_req, ctl_we, ctl_addr, ctl_wdata,
      input ctl_ack, ctl_rdata
   );
   // Device end answers
   modport dev_mp (
      input power_down_input, ctl_req, ctl_we, ctl_addr, ctl_wdata,
      output ctl_ack, ctl_rdata
   );
endinterface
`default_nettype wire

// File: logic/bringup_pkg.sv
// Purpose: shared constants and types for the link bring-up sequencer
// Assumes: pclk at 25 MHz; control bus bytes are 8 bits
// Notes: millisecond figures are converted to cycle counts here
`default_nettype none
package bringup_pkg;
   // Clock and sequencing times
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned SUPPLY_TO_PD_MS = 0;
   localparam int unsigned PD_HIGH_BEFORE_HARD_MS = 1;
   localparam int unsigned PD_LOW_PULSE_MS = 3;
   localparam int unsigned PD_TO_READY_MS = 2;
   localparam int unsigned SUPPLY_TO_PD_RAW =
      (SUPPLY_TO_PD_MS * CLK_HZ + 999) / 1000;
   localparam int unsigned SUPPLY_TO_PD_CYC =
      (SUPPLY_TO_PD_RAW < 1) ? 1 : SUPPLY_TO_PD_RAW;
   localparam int unsigned PD_HIGH_BEFORE_HARD_CYC =
      (PD_HIGH_BEFORE_HARD_MS * CLK_HZ + 999) / 1000;
   localparam int unsigned PD_LOW_PULSE_CYC =
      (PD_LOW_PULSE_MS * CLK_HZ + 999) / 1000;
   // Readiness limit, an upper bound: rounds down
   localparam int unsigned PD_TO_READY_CYC = (PD_TO_READY_MS * CLK_HZ) / 1000;
   localparam int unsigned CNT_W = 20;
   // Device-side small counts
   localparam logic [1:0] TERM_ON_DELAY_CYC = 2'h2;
   localparam logic [4:0] LOCK_CYC = 5'h10;
   // Control-bus register map of the device
   localparam logic [7:0] REG_SOFT_RESET = 8'h01;
   localparam logic [7:0] REG_LANE_CFG = 8'h02;
   localparam logic [7:0] REG_WDOG = 8'h0a;
   localparam logic [7:0] REG_DYN = 8'h4b;
   localparam logic [7:0] REG_STATIC = 8'h4c;
   localparam logic [7:0] WDOG_SPEEDUP_VAL = 8'h12;
   localparam logic [7:0] SOFT_RESET_VAL = 8'h01;
   localparam logic [7:0] STATIC_KEEP_MASK = 8'h8f;
   localparam logic [7:0] STATIC_FIELD_VAL = 8'h70;
   localparam int unsigned STATIC_LSB = 4;
   localparam logic [7:0] DYN_ENABLE_MASK = 8'h20;
   localparam int unsigned DYN_ENABLE_BIT = 5;
   localparam logic [7:0] RST_WDOG = 8'h00;
   localparam logic [7:0] RST_DYN = 8'h10;
   localparam logic [7:0] RST_STATIC = 8'h00;
   localparam logic [1:0] RST_LANE_CFG = 2'h0;
   // Serial rates in Mbps
   localparam logic [15:0] SYNC_RATE_MBPS = 16'h1040;
   localparam logic [15:0] NONSYNC_RATE_MBPS = 16'h0800;
   // Controller APB map
   localparam logic [11:0] APB_CTRL = 12'h000;
   localparam logic [11:0] APB_STATUS = 12'h004;
   localparam logic [11:0] APB_RESULT = 12'h008;
   // Controller sequence states
   typedef enum logic [3:0] {
      ST_OFF = 4'h0, ST_WAIT_READY = 4'h1, ST_IDLE = 4'h2, ST_WDOG = 4'h3,
      ST_RD_STATIC = 4'h4, ST_WR_STATIC = 4'h5, ST_TEMP = 4'h6,
      ST_RD_DYN = 4'h7, ST_WR_DYN = 4'h8, ST_SOFT_RST = 4'h9,
      ST_WAIT_LOCK = 4'ha, ST_DONE = 4'hb, ST_HR_WAIT = 4'hc,
      ST_HR_LOW = 4'hd
   } host_state_t;
endpackage
`default_nettype wire

// File: logic/link_serializer_end.sv
// Purpose: device end: readiness, register file, clocking, lane termination
// Assumes: power_down_input and control port are on pclk
// Notes: pins backchannel_clk_present and lane_hs_request are filtered
`timescale 1ns/10ps
`default_nettype none
module link_serializer_end #(
   parameter int unsigned READY_CYC = bringup_pkg::PD_TO_READY_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   bringup_if.dev_mp ctl,
   input wire logic sync_mode,
   input wire logic backchannel_clk_present,
   input wire logic [3:0] lane_hs_request,
   output logic ctl_ready,
   output logic ref_from_backchannel,
   output logic pll_locked,
   output logic [3:0] lane_termination_en,
   output logic [15:0] serial_rate_mbps,
   output logic ramp_cfg_applied
);
   import bringup_pkg::*;

   logic [4:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   logic [CNT_W-1:0] rdy_cnt_q;
   logic ready_q, ack_q;
   logic [7:0] rdata_q, wdog_q, dyn_q, static_q;
   logic [1:0] lane_cfg_q;
   logic [4:0] lock_cnt_q;
   logic lock_q, bc_prev_q;
   logic take, wr, soft_rst, relock, bc_ok;
   logic [3:0] lane_en;
   logic [7:0] rd_mux;

   // Pin filter: change taken once stages two and three agree
   assign filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 5'h00;
         s2_q <= 5'h00;
         s3_q <= 5'h00;
         filt_q <= 5'h00;
      end else begin
         s1_q <= {backchannel_clk_present, lane_hs_request};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   // ready within the limit after pin rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_cnt_q <= '0;
         ready_q <= 1'b0;
      end else if (!ctl.power_down_input) begin
         rdy_cnt_q <= '0;
         ready_q <= 1'b0;
      end else if (!ready_q) begin
         rdy_cnt_q <= rdy_cnt_q + 1'b1;
         ready_q <= (rdy_cnt_q >= CNT_W'(READY_CYC - 1));
      end
   end

   // Access decode; requests wait unanswered until ready
   assign take = ctl.ctl_req & ready_q & ~ack_q;
   assign wr = take & ctl.ctl_we;
   assign soft_rst = wr & (ctl.ctl_addr == REG_SOFT_RESET)
                     & ctl.ctl_wdata[0];
   assign rd_mux = (ctl.ctl_addr == REG_WDOG) ? wdog_q :
                   (ctl.ctl_addr == REG_DYN) ? dyn_q :
                   (ctl.ctl_addr == REG_STATIC) ? static_q :
                   (ctl.ctl_addr == REG_LANE_CFG) ? {6'h00, lane_cfg_q} :
                   8'h00;

   // pin low returns registers to defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
         wdog_q <= RST_WDOG;
         dyn_q <= RST_DYN;
         static_q <= RST_STATIC;
         lane_cfg_q <= RST_LANE_CFG;
      end else if (!ctl.power_down_input) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
         wdog_q <= RST_WDOG;
         dyn_q <= RST_DYN;
         static_q <= RST_STATIC;
         lane_cfg_q <= RST_LANE_CFG;
      end else begin
         ack_q <= take;
         if (take) rdata_q <= rd_mux;
         if (wr && ctl.ctl_addr == REG_WDOG) wdog_q <= ctl.ctl_wdata;
         if (wr && ctl.ctl_addr == REG_DYN) dyn_q <= ctl.ctl_wdata;
         if (wr && ctl.ctl_addr == REG_STATIC) static_q <= ctl.ctl_wdata;
         if (wr && ctl.ctl_addr == REG_LANE_CFG) begin
            lane_cfg_q <= ctl.ctl_wdata[1:0];
         end
      end
   end
   assign ctl.ctl_ack = ack_q;
   assign ctl.ctl_rdata = rdata_q;
   assign ctl_ready = ready_q;

   // reference from recovered clock, relock on return
   assign bc_ok = filt_q[4];
   assign ref_from_backchannel = sync_mode & bc_ok;
   assign relock = soft_rst | (sync_mode & bc_ok & ~bc_prev_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_prev_q <= 1'b0;
         lock_cnt_q <= 5'h00;
         lock_q <= 1'b0;
      end else begin
         bc_prev_q <= bc_ok;
         if (!ctl.power_down_input || relock || (sync_mode && !bc_ok)) begin
            lock_cnt_q <= 5'h00;
            lock_q <= 1'b0;
         end else if (!lock_q) begin
            lock_cnt_q <= lock_cnt_q + 5'h01;
            lock_q <= (lock_cnt_q == LOCK_CYC - 5'h01);
         end
      end
   end
   assign pll_locked = lock_q;

   assign serial_rate_mbps = sync_mode ? SYNC_RATE_MBPS : NONSYNC_RATE_MBPS;

   // ramp configuration in effect while locked
   assign ramp_cfg_applied = dyn_q[DYN_ENABLE_BIT]
      & (static_q[STATIC_LSB+2:STATIC_LSB] == 3'h7) & lock_q;

   // one, two or four lanes; code 3 treated as one
   assign lane_en = (lane_cfg_q == 2'h1) ? 4'h3 :
                    (lane_cfg_q == 2'h2) ? 4'hf : 4'h1;

   // per-lane termination shortly after HS entry
   for (genvar i = 0; i < 4; i++) begin : g_lane
      logic [1:0] dly_q;
      logic term_q;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dly_q <= 2'h0;
            term_q <= 1'b0;
         end else if (!(filt_q[i] && lane_en[i] && ctl.power_down_input)) begin
            dly_q <= 2'h0;
            term_q <= 1'b0;
         end else if (!term_q) begin
            dly_q <= dly_q + 2'h1;
            term_q <= (dly_q == TERM_ON_DELAY_CYC - 2'h1);
         end
      end
      assign lane_termination_en[i] = term_q;
   end
endmodule // link_serializer_end
`default_nettype wire

// File: tb/bringup_assertions.sv
// Purpose: timing and order checks on the link between the two ends
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes: pin-time counters saturate so long runs cannot wrap them
`timescale 1ns/10ps
`default_nettype none
module bringup_assertions
   import bringup_pkg::*;
#(
   parameter int unsigned T2_CYC = 10,
   parameter int unsigned T3_CYC = 20,
   parameter int unsigned T4_CYC = 15
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic power_down_input,
   input wire logic ctl_req,
   input wire logic ctl_we,
   input wire logic [7:0] ctl_addr,
   input wire logic [7:0] ctl_wdata,
   input wire logic ctl_ack
);
   logic [19:0] hi_q;
   logic [19:0] lo_q;
   logic seen_q;
   logic wd_q;
   logic dyn_q;
   // Decoded write completions on the control port
   wire logic wr_ack = ctl_ack & ctl_we;
   wire logic wd_ack = wr_ack && ctl_addr == REG_WDOG;
   wire logic dyn_ack = wr_ack && ctl_addr == REG_DYN;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pin high and low times, a pin-seen-high flag, plus progress flags cleared by power down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_q <= '0;
         lo_q <= '0;
         seen_q <= 1'b0;
         wd_q <= 1'b0;
         dyn_q <= 1'b0;
      end else begin
         hi_q <= !power_down_input ? '0 : hi_q + 20'(hi_q != '1);
         lo_q <= power_down_input ? '0 : lo_q + 20'(lo_q != '1);
         seen_q <= seen_q | power_down_input;
         wd_q <= power_down_input & (wd_q | (wd_ack & ctl_wdata == 8'h12));
         dyn_q <= power_down_input & (dyn_q | dyn_ack);
      end
   end
   property p_no_early_access;
      ctl_req |-> hi_q >= T4_CYC;
   endproperty
   a_no_early_access: assert property (p_no_early_access)
      else $error("control access too soon after pin rise");
   property p_ack_next;
      $rose(ctl_req) |-> ##1 ctl_ack;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ready device did not answer next cycle");
   property p_ack_pulse;
      ctl_ack |=> !ctl_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("answer longer than one cycle");
   property p_req_hold;
      ctl_req && !ctl_ack |=> ctl_req && $stable({ctl_we, ctl_addr, ctl_wdata});
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request changed before answer");
   property p_low_pulse;
      $rose(power_down_input) && seen_q |-> lo_q >= T3_CYC;
   endproperty
   a_low_pulse: assert property (p_low_pulse)
      else $error("pin low pulse too short");
   property p_high_before_low;
      $fell(power_down_input) |-> hi_q >= T2_CYC;
   endproperty
   a_high_before_low: assert property (p_high_before_low)
      else $error("pin high time too short before low");
   property p_wdog_first;
      ctl_req && ctl_addr != REG_WDOG |-> wd_q;
   endproperty
   a_wdog_first: assert property (p_wdog_first)
      else $error("access before watchdog speedup");
   property p_static_field;
      ctl_req && ctl_we && ctl_addr == REG_STATIC |-> ctl_wdata[6:4] == 3'h7;
   endproperty
   a_static_field: assert property (p_static_field)
      else $error("static ramp field not seven");
   property p_dyn_enable;
      ctl_req && ctl_we && ctl_addr == REG_DYN |-> ctl_wdata[5];
   endproperty
   a_dyn_enable: assert property (p_dyn_enable)
      else $error("dynamic write without enable bit");
   property p_soft_last;
      ctl_req && ctl_we && ctl_addr == REG_SOFT_RESET |->
         ctl_wdata == SOFT_RESET_VAL && dyn_q;
   endproperty
   a_soft_last: assert property (p_soft_last)
      else $error("soft reset wrong value or out of order");
   property p_pd_quiet;
      !power_down_input |=> !ctl_ack;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet)
      else $error("device answered while powered down");
endmodule // bringup_assertions
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench joining controller and device ends
// Assumes: long pin times shortened by parameters
// Notes: temperature codes run from a table, odd cases follow it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import bringup_pkg::*;
   localparam int unsigned T2 = 10;
   localparam int unsigned T3 = 20;
   localparam int unsigned T4 = 15;
   // Rows: temperature code beside its expected offset
   localparam logic [10:0] ROWS [8] = '{{3'h0, 8'hff}, {3'h1, 8'hff},
      {3'h2, 8'h00}, {3'h3, 8'h00}, {3'h4, 8'h01}, {3'h5, 8'h01},
      {3'h6, 8'h01}, {3'h7, 8'h03}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic supply_ok, sync_mode, bc_present, seq_done, ctl_ready;
   logic ref_bc, pll_locked, ramp_applied;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] temp_code;
   logic [3:0] lane_hs, term_en;
   logic [15:0] rate;
   logic [7:0] exp_dyn;
   int err_total, total_checks;
   bringup_if link_if();
   bringup_controller #(.T2_CYC(T2), .T3_CYC(T3), .T4_CYC(T4))
      bringup_controller_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ctl(link_if.host_mp), .core_supply_stable(supply_ok),
      .rx_link_lock(pll_locked), .remote_die_temperature_code(temp_code),
      .sequence_done(seq_done));
   link_serializer_end #(.READY_CYC(T4)) link_serializer_end_inst (
      .pclk(pclk), .presetn(presetn), .ctl(link_if.dev_mp),
      .sync_mode(sync_mode), .backchannel_clk_present(bc_present),
      .lane_hs_request(lane_hs), .ctl_ready(ctl_ready),
      .ref_from_backchannel(ref_bc), .pll_locked(pll_locked),
      .lane_termination_en(term_en), .serial_rate_mbps(rate),
      .ramp_cfg_applied(ramp_applied));
   bringup_assertions #(.T2_CYC(T2), .T3_CYC(T3), .T4_CYC(T4))
      bringup_assertions_inst (.pclk(pclk), .presetn(presetn),
      .power_down_input(link_if.power_down_input), .ctl_req(link_if.ctl_req),
      .ctl_we(link_if.ctl_we), .ctl_addr(link_if.ctl_addr),
      .ctl_wdata(link_if.ctl_wdata), .ctl_ack(link_if.ctl_ack));
   // Free-running 25 MHz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_total++;
         report_and_stop();
      end
   endtask
   // Poll status until the masked field matches
   task automatic poll(input logic [31:0] mask, input logic [31:0] val);
      int n;
      n = 0;
      do begin
         apb(1'b0, APB_STATUS, 32'h0);
         n++;
      end while ((rd & mask) !== val && n < 300);
      if ((rd & mask) !== val) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, rd & mask, val);
         report_and_stop();
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge pclk);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, supply_ok, bc_present} = '0;
      {paddr, pwdata, temp_code, lane_hs} = '0;
      sync_mode = 1'b1;
      err_total = 0;
      total_checks = 0;
      idle(6);
      presetn <= 1'b1;
      bc_present <= 1'b1;
      idle(1);
      chk(32'(link_if.power_down_input), 32'h0);
      supply_ok <= 1'b1;
      poll(32'hf, 32'h2);
      chk(32'(ctl_ready), 32'h1);
      for (int i = 0; i < 8; i++) begin
         temp_code <= ROWS[i][10:8];
         exp_dyn = ((8'h10 | DYN_ENABLE_MASK) + ROWS[i][7:0])
                   | DYN_ENABLE_MASK;
         apb(1'b1, APB_CTRL, 32'h2);
         poll(32'hf, 32'h2);
         apb(1'b1, APB_CTRL, 32'h1);
         poll(32'h10, 32'h10);
         chk(32'(rd[9:7]), 32'(ROWS[i][10:8]));
         apb(1'b0, APB_RESULT, 32'h0);
         chk(rd, {8'h00, exp_dyn, 8'h10, 8'h70});
         chk(32'(rd[15:8]), 32'(RST_DYN));
         chk(32'(ramp_applied), 32'h1);
         $display("test code %0d done", i);
      end
      // Unmapped APB address is refused
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      chk(32'(slv), 32'h1);
      // Clocking mode, rate and back-channel reference
      chk(32'(rate), 32'h1040);
      sync_mode <= 1'b0;
      idle(2);
      chk(32'(rate), 32'h0800);
      sync_mode <= 1'b1;
      bc_present <= 1'b0;
      idle(8);
      chk(32'(ref_bc), 32'h0);
      bc_present <= 1'b1;
      idle(40);
      chk(32'(ref_bc), 32'h1);
      chk(32'(pll_locked), 32'h1);
      // Default lane config terminates lane 0 only
      lane_hs <= 4'hf;
      idle(8);
      chk(32'(term_en), 32'h1);
      lane_hs <= 4'h0;
      idle(8);
      chk(32'(term_en), 32'h0);
      $display("test device side done");
      // Supply loss drops the pin and restarts bring-up
      supply_ok <= 1'b0;
      idle(8);
      chk(32'(link_if.power_down_input), 32'h0);
      chk(32'(ctl_ready), 32'h0);
      idle(30);
      supply_ok <= 1'b1;
      poll(32'hf, 32'h2);
      // Reset in mid-sequence
      apb(1'b1, APB_CTRL, 32'h1);
      idle(3);
      presetn <= 1'b0;
      idle(2);
      chk(32'(seq_done), 32'h0);
      presetn <= 1'b1;
      idle(1);
      chk(32'(link_if.power_down_input), 32'h0);
      poll(32'hf, 32'h2);
      $display("test faults done");
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
